// >>> cmir_pkg.sv
`default_nettype none

package cmir_pkg;

  // ---------------------------------------------------------------------------
  // Request line numbers
  // ---------------------------------------------------------------------------
  localparam int unsigned LINE_HW_ERROR  = 0;
  localparam int unsigned LINE_STD_IO    = 1;
  localparam int unsigned LINE_EXP_IO    = 2;
  localparam int unsigned LINE_IPI       = 3;
  localparam int unsigned LINE_TIMER     = 4;
  localparam int unsigned LINE_SYS_EVENT = 5;
  localparam int unsigned NUM_LINES      = 6;

  // ---------------------------------------------------------------------------
  // Interrupt clear register bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CLR_HW_ERROR   = 0;
  localparam int unsigned CLR_TIMER      = 1;
  localparam int unsigned CLR_IPI        = 2;
  localparam int unsigned CLR_SYS_EVENT  = 3;
  localparam int unsigned CLR_NODE_HALT  = 4;
  localparam int unsigned CLR_SERIAL     = 5;
  localparam int unsigned CLR_PERF0      = 6;
  localparam int unsigned CLR_PERF1      = 7;
  localparam int unsigned CLR_WIDTH      = 8;

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned LOCAL_IO_WIDTH  = 16;
  localparam int unsigned NUM_CPUS        = 2;
  localparam int unsigned PERF_WIDTH      = 16;
  localparam logic [15:0] PERF_LIMIT_RST  = 16'hFFFF;
  localparam logic [5:0]  ENABLE_RST      = 6'h00;

  // ---------------------------------------------------------------------------
  // Interval timer: 976.5625 us at 50 MHz
  // ---------------------------------------------------------------------------
  localparam real         TIMER_PERIOD_US = 976.5625;
  localparam real         CLOCK_MHZ       = 50.0;
  localparam int unsigned TIMER_CYCLES    = int'(TIMER_PERIOD_US * CLOCK_MHZ);
  localparam int unsigned TIMER_WIDTH     = 16;

endpackage : cmir_pkg

`default_nettype wire

// >>> cmir_edge_flag.sv
`timescale 1ns/1ps
`default_nettype none

// Sticky pending flag: a set in the same cycle as a clear wins.
module cmir_edge_flag
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic set,
  input  wire logic clear,
  output var  logic pending_q
);

  logic pending_d;

  assign pending_d = set | (pending_q & ~clear);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pending_q <= 1'b0;
    else
      pending_q <= pending_d;
  end

endmodule // cmir_edge_flag

`default_nettype wire

// >>> cmir_perf_counter.sv
`timescale 1ns/1ps
`default_nettype none

// Event counter that raises a one-cycle overflow pulse at the programmed limit.
module cmir_perf_counter
(
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  input  wire logic                           enable,
  input  wire logic                           count_event,
  input  wire logic [cmir_pkg::PERF_WIDTH-1:0] limit,
  output var  logic                           overflow_q
);

  logic [cmir_pkg::PERF_WIDTH-1:0] count_q;
  logic [cmir_pkg::PERF_WIDTH-1:0] count_d;
  logic [cmir_pkg::PERF_WIDTH-1:0] count_inc;
  logic                            reached;

  // The event that brings the count up to the limit is the one that fires,
  // so a limit of n interrupts after exactly n events.
  assign count_inc = count_q + 1'b1;
  assign reached   = enable & count_event & (count_inc >= limit);
  assign count_d   = !enable ? '0 :
                     reached ? '0 :
                     count_event ? count_inc : count_q;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      count_q    <= '0;
      overflow_q <= 1'b0;
    end
    else
    begin
      count_q    <= count_d;
      overflow_q <= reached;
    end
  end

endmodule // cmir_perf_counter

`default_nettype wire

// >>> cmir_router.sv
`timescale 1ns/1ps
`default_nettype none

module cmir_router
(
  input  wire logic                               clock,
  input  wire logic                               rst_b,
  // Shared bus error reporting.
  input  wire logic                               bus_cmd_valid,
  input  wire logic                               bus_cmd_acked,
  input  wire logic                               bus_cmd_from_self,
  input  wire logic                               bus_cmd_from_io,
  input  wire logic                               bus_error_in_b,
  input  wire logic                               dup_tag_parity_error,
  output var  logic                               bus_error_out_b,
  output var  logic                               bus_error_out_en,
  output var  logic                               machine_check_q,
  output var  logic                               uncorrectable_error_q,
  // Local and expansion I/O requests.
  input  wire logic [cmir_pkg::LOCAL_IO_WIDTH-1:0] local_io_request,
  input  wire logic [cmir_pkg::LOCAL_IO_WIDTH-1:0] local_io_clear,
  output var  logic [cmir_pkg::LOCAL_IO_WIDTH-1:0] local_io_pending_q,
  input  wire logic                               expansion_io_request,
  // Interprocessor request register write.
  input  wire logic                               ipi_write,
  input  wire logic [cmir_pkg::NUM_CPUS-1:0]       ipi_target,
  input  wire logic [cmir_pkg::NUM_CPUS-1:0]       cpu_id_onehot,
  // System events.
  input  wire logic                               power_status_change,
  input  wire logic                               panel_halt_request,
  input  wire logic                               node_halt_request,
  input  wire logic                               network_event,
  // Serial line and performance counters.
  input  wire logic                               serial_rx,
  input  wire logic [1:0]                         perf_enable,
  input  wire logic [1:0]                         perf_event,
  input  wire logic [cmir_pkg::PERF_WIDTH-1:0]     perf_limit_0,
  input  wire logic [cmir_pkg::PERF_WIDTH-1:0]     perf_limit_1,
  // Interrupt clear register write and enable mask.
  input  wire logic                               clear_write,
  input  wire logic [cmir_pkg::CLR_WIDTH-1:0]      interrupt_clear_register,
  input  wire logic [cmir_pkg::NUM_LINES-1:0]      hw_irq_enable_mask_reg,
  // Toward the processor core.
  output var  logic [cmir_pkg::NUM_LINES-1:0]      hw_irq_request_level,
  output var  logic                               serial_irq_q,
  output var  logic [1:0]                         perf_irq_q,
  output var  logic [cmir_pkg::CLR_WIDTH-1:0]      pending_status
);

  // ---------------------------------------------------------------------------
  // Clear strobes
  // ---------------------------------------------------------------------------
  function automatic logic clear_bit(input logic wr,
                                     input logic [cmir_pkg::CLR_WIDTH-1:0] data,
                                     input int unsigned pos);
    clear_bit = wr & data[pos];
  endfunction

  logic clr_hw_error;
  logic clr_timer;
  logic clr_ipi;
  logic clr_sys_event;
  logic clr_node_halt;
  logic clr_serial;
  logic clr_perf0;
  logic clr_perf1;

  assign clr_hw_error  = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_HW_ERROR);
  assign clr_timer     = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_TIMER);
  assign clr_ipi       = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_IPI);
  assign clr_sys_event = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_SYS_EVENT);
  assign clr_node_halt = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_NODE_HALT);
  assign clr_serial    = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_SERIAL);
  assign clr_perf0     = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_PERF0);
  assign clr_perf1     = clear_bit(clear_write, interrupt_clear_register, cmir_pkg::CLR_PERF1);

  // ---------------------------------------------------------------------------
  // Bus error detection
  // ---------------------------------------------------------------------------
  // An unacked command is an invalid address; when this CPU or the I/O module
  // issued it, the shared line is pulled so every CPU sees the error.
  logic unacked_cmd;
  logic drive_error;
  logic hw_error_set;

  assign unacked_cmd  = bus_cmd_valid & ~bus_cmd_acked;
  assign drive_error  = (unacked_cmd & (bus_cmd_from_self | bus_cmd_from_io))
                        | dup_tag_parity_error;
  // Error reports from memory or the I/O module arrive on the shared line.
  assign hw_error_set = drive_error | ~bus_error_in_b;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      bus_error_out_b       <= 1'b1;
      bus_error_out_en      <= 1'b0;
      machine_check_q       <= 1'b0;
      uncorrectable_error_q <= 1'b0;
    end
    else
    begin
      bus_error_out_b       <= ~drive_error;
      bus_error_out_en      <= drive_error;
      machine_check_q       <= unacked_cmd & bus_cmd_from_self;
      // Reported as uncorrectable, but nothing is invalidated; the shared line is also pulled and hw_error_q is set.
      uncorrectable_error_q <= dup_tag_parity_error;
    end
  end

  // ---------------------------------------------------------------------------
  // Local I/O pending bits
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < cmir_pkg::LOCAL_IO_WIDTH; g++)
    begin : g_local_io
      cmir_edge_flag u_flag
      (
        .clock     (clock),
        .rst_b     (rst_b),
        .set       (local_io_request[g]),
        .clear     (local_io_clear[g]),
        .pending_q (local_io_pending_q[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Interval timer
  // ---------------------------------------------------------------------------
  logic [cmir_pkg::TIMER_WIDTH-1:0] timer_q;
  logic [cmir_pkg::TIMER_WIDTH-1:0] timer_d;
  logic                             timer_tick;

  assign timer_tick = (timer_q == cmir_pkg::TIMER_WIDTH'(cmir_pkg::TIMER_CYCLES - 1));
  assign timer_d    = timer_tick ? '0 : timer_q + 1'b1;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      timer_q <= '0;
    else
      timer_q <= timer_d;
  end

  // ---------------------------------------------------------------------------
  // Serial line change detect
  // ---------------------------------------------------------------------------
  logic serial_rx_q;
  logic serial_change;

  assign serial_change = serial_rx ^ serial_rx_q;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      serial_rx_q <= 1'b1;
    else
      serial_rx_q <= serial_rx;
  end

  // ---------------------------------------------------------------------------
  // Performance counters
  // ---------------------------------------------------------------------------
  logic [1:0] perf_overflow;

  cmir_perf_counter u_perf0
  (
    .clock       (clock),
    .rst_b       (rst_b),
    .enable      (perf_enable[0]),
    .count_event (perf_event[0]),
    .limit       (perf_limit_0),
    .overflow_q  (perf_overflow[0])
  );

  cmir_perf_counter u_perf1
  (
    .clock       (clock),
    .rst_b       (rst_b),
    .enable      (perf_enable[1]),
    .count_event (perf_event[1]),
    .limit       (perf_limit_1),
    .overflow_q  (perf_overflow[1])
  );

  // ---------------------------------------------------------------------------
  // Sticky pending sources
  // ---------------------------------------------------------------------------
  logic hw_error_q;
  logic timer_q_pend;
  logic ipi_q;
  logic sys_event_q;
  logic node_halt_q;
  logic ipi_set;
  logic sys_event_set;

  assign ipi_set       = ipi_write & |(ipi_target & cpu_id_onehot);
  assign sys_event_set = power_status_change | panel_halt_request
                         | network_event;

  // Each flag merges repeated events while pending; only a 1 written to its
  // clear bit drops it, and a same-cycle event still wins.
  cmir_edge_flag u_hw_error
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (hw_error_set),
    .clear     (clr_hw_error),
    .pending_q (hw_error_q)
  );

  cmir_edge_flag u_timer
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (timer_tick),
    .clear     (clr_timer),
    .pending_q (timer_q_pend)
  );

  cmir_edge_flag u_ipi
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (ipi_set),
    .clear     (clr_ipi),
    .pending_q (ipi_q)
  );

  cmir_edge_flag u_sys_event
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (sys_event_set),
    .clear     (clr_sys_event),
    .pending_q (sys_event_q)
  );

  cmir_edge_flag u_node_halt
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (node_halt_request),
    .clear     (clr_node_halt),
    .pending_q (node_halt_q)
  );

  cmir_edge_flag u_serial
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (serial_change),
    .clear     (clr_serial),
    .pending_q (serial_irq_q)
  );

  cmir_edge_flag u_perf_f0
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (perf_overflow[0]),
    .clear     (clr_perf0),
    .pending_q (perf_irq_q[0])
  );

  cmir_edge_flag u_perf_f1
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .set       (perf_overflow[1]),
    .clear     (clr_perf1),
    .pending_q (perf_irq_q[1])
  );

  // ---------------------------------------------------------------------------
  // Request line assembly
  // ---------------------------------------------------------------------------
  // The mask is applied here so a non-primary CPU with line 1 masked never
  // sees local I/O; pending bits still accumulate underneath the mask.
  logic [cmir_pkg::NUM_LINES-1:0] raw_lines;

  assign raw_lines[cmir_pkg::LINE_HW_ERROR]  = hw_error_q;
  assign raw_lines[cmir_pkg::LINE_STD_IO]    = |local_io_pending_q;
  assign raw_lines[cmir_pkg::LINE_EXP_IO]    = expansion_io_request;
  assign raw_lines[cmir_pkg::LINE_IPI]       = ipi_q;
  assign raw_lines[cmir_pkg::LINE_TIMER]     = timer_q_pend;
  assign raw_lines[cmir_pkg::LINE_SYS_EVENT] = sys_event_q | node_halt_q;

  assign hw_irq_request_level = raw_lines & hw_irq_enable_mask_reg;

  assign pending_status = {perf_irq_q[1], perf_irq_q[0], serial_irq_q, node_halt_q,
                           sys_event_q, ipi_q, timer_q_pend, hw_error_q};

endmodule // cmir_router

`default_nettype wire

// >>> cmir_bus_far.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------------
// Far side of the shared error line: responders, memory and the I/O commander.
// -----------------------------------------------------------------------------
module cmir_bus_far
(
  input  wire logic cmd_valid,
  input  wire logic addr_valid,
  input  wire logic parity_bad,
  input  wire logic dut_err_b,
  input  wire logic dut_err_en,
  input  wire logic correctable_read_report,
  input  wire logic mem_correctable,
  input  wire logic io_uncorrectable,
  output var  logic cmd_acked,
  output var  logic err_line_b
);
  // A cycle with bad parity is never acked, even to a valid address.
  assign cmd_acked = cmd_valid && addr_valid && !parity_bad;
  // The line is pulled up, so it rests high whenever nobody pulls it down.
  assign err_line_b = !((dut_err_en && !dut_err_b) || io_uncorrectable
                        || (mem_correctable && correctable_read_report));
endmodule // cmir_bus_far

`default_nettype wire

// >>> cmir_router_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cmir_router_chk
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        bus_cmd_valid,
  input wire logic        bus_cmd_acked,
  input wire logic        bus_cmd_from_self,
  input wire logic        bus_cmd_from_io,
  input wire logic        bus_error_in_b,
  input wire logic        dup_tag_parity_error,
  input wire logic        bus_error_out_en,
  input wire logic        machine_check_q,
  input wire logic        uncorrectable_error_q,
  input wire logic [15:0] local_io_request,
  input wire logic [15:0] local_io_pending_q,
  input wire logic        ipi_write,
  input wire logic [1:0]  ipi_target,
  input wire logic [1:0]  cpu_id_onehot,
  input wire logic        power_status_change,
  input wire logic        panel_halt_request,
  input wire logic        network_event,
  input wire logic        serial_rx,
  input wire logic [1:0]  perf_event,
  input wire logic        clear_write,
  input wire logic [7:0]  interrupt_clear_register,
  input wire logic [5:0]  hw_irq_enable_mask_reg,
  input wire logic [5:0]  hw_irq_request_level,
  input wire logic        serial_irq_q,
  input wire logic [1:0]  perf_irq_q,
  input wire logic [7:0]  pending_status
);
  // ---------------------------------------------------------------------------
  // Timer phase, counted from reset so a late or early tick shows up.
  // ---------------------------------------------------------------------------
  int unsigned gap_q;
  always_ff @(posedge clock)
  begin
    gap_q <= !rst_b ? 0 : (gap_q == cmir_pkg::TIMER_CYCLES) ? 1 : gap_q + 1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_ipi_post: assert property (ipi_write && |(ipi_target & cpu_id_onehot)
    |=> pending_status[2]) else $error("ipi not posted");
  a_own_unacked: assert property (bus_cmd_valid && !bus_cmd_acked && bus_cmd_from_self
    |=> machine_check_q && bus_error_out_en && pending_status[0]) else $error("own unacked");
  a_io_unacked: assert property (bus_cmd_valid && !bus_cmd_acked && bus_cmd_from_io
    && !bus_cmd_from_self |=> pending_status[0] && !machine_check_q) else $error("io unacked");
  a_shared_err: assert property (!bus_error_in_b |=> pending_status[0])
    else $error("shared error line ignored");
  a_dup_tag: assert property (dup_tag_parity_error |=> uncorrectable_error_q)
    else $error("dup tag error not reported");
  a_local_set: assert property (|local_io_request |=>
    (local_io_pending_q & $past(local_io_request)) == $past(local_io_request))
    else $error("local request lost");
  a_line_map: assert property ((hw_irq_request_level[5:3] == ({|pending_status[4:3],
    pending_status[1], pending_status[2]} & hw_irq_enable_mask_reg[5:3])) &&
    (hw_irq_request_level[1:0] == ({|local_io_pending_q, pending_status[0]}
    & hw_irq_enable_mask_reg[1:0]))) else $error("request line map wrong");
  a_sys_event: assert property (power_status_change || panel_halt_request || network_event
    |=> pending_status[3]) else $error("system event lost");
  a_sys_clear: assert property (clear_write && interrupt_clear_register[3] &&
    !(power_status_change || panel_halt_request || network_event) |=> !pending_status[3])
    else $error("system event not cleared");
  a_event_hold: assert property (pending_status[4] &&
    !(clear_write && interrupt_clear_register[4]) |=> pending_status[4])
    else $error("node halt dropped");
  a_timer_period: assert property ($rose(pending_status[1]) |->
    gap_q == cmir_pkg::TIMER_CYCLES) else $error("timer period wrong");
  a_serial_edge: assert property ($changed(serial_rx) |=> serial_irq_q)
    else $error("serial change missed");
  a_perf_overflow: assert property ($rose(perf_irq_q[0]) |-> $past(perf_event[0], 2))
    else $error("perf flag without event");

  cover property (ipi_write ##1 pending_status[2]);
  cover property ($rose(pending_status[1]));
  cover property ($rose(perf_irq_q[0]));
endmodule // cmir_router_chk

bind cmir_router cmir_router_chk chk_u (.*);

`default_nettype wire

// >>> tb_cpu_module_interrupt_router.sv
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_module_interrupt_router;
  logic        clock, rst_b, cmd_v, self_c, io_c, addr_ok, par_bad, dup, exp_io, ipi_w;
  logic        ser, clr_w, mem_ce, crr_en, io_uce, acked, err_in_b, err_b, err_en, mc, uce;
  logic        s_irq;
  logic [15:0] lreq, lclr, lpend, plim, e;
  logic [7:0]  icr, pstat;
  logic [7:0]  tbl [7] = '{8'hc0, 8'hd8, 8'hd0, 8'ha0, 8'h14, 8'h12, 8'h13};
  logic [5:0]  mask, lines;
  logic [3:0]  evt;
  logic [1:0]  tgt, cpu, pen, pev, pirq;
  int          mismatches, checks_done, cyc, n, r;

  cmir_bus_far far_u (.cmd_valid(cmd_v), .addr_valid(addr_ok), .parity_bad(par_bad),
    .dut_err_b(err_b), .dut_err_en(err_en), .correctable_read_report(crr_en),
    .mem_correctable(mem_ce),
    .io_uncorrectable(io_uce), .cmd_acked(acked), .err_line_b(err_in_b));

  cmir_router dut_u (.clock(clock), .rst_b(rst_b), .bus_cmd_valid(cmd_v),
    .bus_cmd_acked(acked), .bus_cmd_from_self(self_c), .bus_cmd_from_io(io_c),
    .bus_error_in_b(err_in_b), .dup_tag_parity_error(dup), .bus_error_out_b(err_b),
    .bus_error_out_en(err_en), .machine_check_q(mc), .uncorrectable_error_q(uce),
    .local_io_request(lreq), .local_io_clear(lclr), .local_io_pending_q(lpend),
    .expansion_io_request(exp_io), .ipi_write(ipi_w), .ipi_target(tgt), .cpu_id_onehot(cpu),
    .power_status_change(evt[0]), .panel_halt_request(evt[1]), .network_event(evt[2]),
    .node_halt_request(evt[3]), .serial_rx(ser), .perf_enable(pen), .perf_event(pev),
    .perf_limit_0(plim), .perf_limit_1(plim), .clear_write(clr_w),
    .interrupt_clear_register(icr), .hw_irq_enable_mask_reg(mask),
    .hw_irq_request_level(lines), .serial_irq_q(s_irq), .perf_irq_q(pirq),
    .pending_status(pstat));

  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers.
  // ---------------------------------------------------------------------------
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The clear write is held for exactly one edge, as the clear register expects.
  task automatic clr(input logic [7:0] b);
    @(posedge clock);
    {clr_w, icr} <= {1'h1, b};
    @(posedge clock);
    {clr_w, icr} <= 9'h000;
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial
  begin
    {clock, cmd_v, self_c, io_c, par_bad, dup, exp_io, ipi_w, clr_w, mem_ce, crr_en} = '0;
    {io_uce, rst_b, lreq, lclr, icr, evt, tgt, pen, pev, mismatches, checks_done, cyc} = '0;
    {addr_ok, ser, cpu, mask, plim} = {2'h3, 2'h1, 6'h3f, 16'h0004};
    void'($urandom(32'h293e));
    repeat (10) @(posedge clock);
    rst_b <= 1'h1;
    for (int k = 0; k < 7; k++)
    begin
      @(posedge clock);
      {cmd_v, self_c, io_c, addr_ok, par_bad, io_uce, mem_ce, crr_en} <= tbl[k];
      @(posedge clock);
      {cmd_v, self_c, io_c, addr_ok, par_bad, io_uce, mem_ce, crr_en} <= 8'h10;
      #1;
      chk("machine check", 16'(7'h03 >> k & 7'h01), 16'(mc));
      chk("hw error flag", 16'(7'h5b >> k & 7'h01), 16'(pstat[0]));
      repeat (3) @(posedge clock);
      clr(8'h01);
      chk("line0 cleared", 16'h0000, 16'(lines[0]));
    end
    $display("test bus errors done");
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom;
      e = (k == 0) ? 16'hffff : r[15:0];
      @(posedge clock);
      {lreq, mask} <= {e, 6'h3d};
      @(posedge clock);
      lreq <= 16'h0000;
      #1;
      chk("local pending", e, lpend);
      chk("line1 masked", 16'h0000, 16'(lines[1]));
      @(posedge clock);
      {lclr, mask} <= {r[31:16], 6'h3f};
      @(posedge clock);
      lclr <= 16'hffff;
      e = e & ~r[31:16];
      #1;
      chk("local after clear", e, lpend);
      chk("line1", 16'(|e), 16'(lines[1]));
      @(posedge clock);
      lclr <= 16'h0000;
    end
    $display("test local io done");
    for (int k = 0; k < 6; k++)
    begin
      r = $urandom;
      @(posedge clock);
      {ipi_w, tgt, cpu, exp_io} <= {1'h1, r[1:0], r[2] ? 2'h2 : 2'h1, r[3]};
      repeat (2) @(posedge clock);
      ipi_w <= 1'h0;
      #1;
      chk("ipi flag", 16'(|(r[1:0] & cpu)), 16'(pstat[2]));
      chk("line3", 16'(|(r[1:0] & cpu)), 16'(lines[3]));
      chk("line2", 16'(r[3]), 16'(lines[2]));
      clr(8'h04);
      chk("ipi cleared", 16'h0000, 16'(pstat[2]));
    end
    $display("test interprocessor done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock);
      evt <= 4'h1 << k;
      @(posedge clock);
      evt <= 4'h0;
      #1;
      chk("line5 set", 16'h0001, 16'(lines[5]));
      clr(k == 3 ? 8'h08 : 8'h10);
      chk("line5 held", 16'h0001, 16'(lines[5]));
      clr(k == 3 ? 8'h10 : 8'h08);
      chk("line5 cleared", 16'h0000, 16'(lines[5]));
    end
    $display("test system events done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      {ser, dup} <= {~ser, 1'h1};
      @(posedge clock);
      dup <= 1'h0;
      #1;
      chk("serial flag", 16'h0001, 16'(s_irq));
      chk("uncorrectable", 16'h0001, 16'(uce));
      clr(8'h21);
      chk("serial cleared", 16'h0000, 16'(s_irq));
    end
    $display("test serial and tag done");
    for (int j = 0; j < 2; j++)
    begin
      n = 3 + $urandom % 6;
      @(posedge clock);
      {pen, plim} <= {2'h3, 16'(n)};
      @(posedge clock);
      pev <= 2'h1 << j;
      repeat (n - 1) @(posedge clock);
      pev <= 2'h0;
      repeat (4) @(posedge clock);
      #1;
      chk("perf early", 16'h0000, 16'(pirq[j]));
      @(posedge clock);
      pev <= 2'h1 << j;
      @(posedge clock);
      pev <= 2'h0;
      repeat (2) @(posedge clock);
      #1;
      chk("perf overflow", 16'h0001, 16'(pirq[j]));
      clr(8'h40 << j);
    end
    $display("test perf counters done");
    @(posedge clock);
    {rst_b, exp_io} <= 2'h0;
    repeat (10) @(posedge clock);
    #1;
    chk("reset local", 16'h0000, lpend);
    chk("reset status", 16'h0000, {pstat, 2'h0, lines});
    chk("reset drive", 16'h0001, {14'h0000, err_en, err_b});
    @(posedge clock);
    rst_b <= 1'h1;
    n = 0;
    while (lines[4] !== 1'h1 && n < 60000)
    begin
      @(posedge clock);
      n++;
      #1;
    end
    chk("timer period", 16'(cmir_pkg::TIMER_CYCLES), 16'(n));
    clr(8'h02);
    chk("timer cleared", 16'h0000, 16'(lines[4]));
    $display("test timer done");
    wrap_up();
  end
endmodule // tb_cpu_module_interrupt_router

`default_nettype wire
